// file: pkg/pev_pkg.sv
/*
 Package for the partner page, receive error count and event register slice.
 Assumes a management port with 5-bit register address and 16-bit data.
*/
package pev_pkg;
    // Register addresses
    localparam logic [4:0] ADDR_PARTNER_NEXT_PAGE = 5'h08;
    localparam logic [4:0] ADDR_RX_SYMBOL_ERR_CNT = 5'h15;
    localparam logic [4:0] ADDR_EVENT_CTRL = 5'h1B;
    // Field positions in the event register
    localparam int EN_LSB = 8;
    localparam int FLAG_LSB = 0;
    // Field positions in the partner page register
    localparam int PNP_NEXT = 15;
    localparam int PNP_ACK = 14;
    localparam int PNP_MSG = 13;
    localparam int PNP_ACK2 = 12;
    localparam int PNP_TOGGLE = 11;
    // Reset values
    localparam logic [7:0] EVENT_EN_RST = 8'h00;
    localparam logic [7:0] EVENT_FLAG_RST = 8'h00;
    localparam logic [15:0] PARTNER_PAGE_RST = 16'h0000;
    localparam logic [15:0] ERR_CNT_RST = 16'h0000;
    localparam logic [15:0] ERR_CNT_MAX = 16'hFFFF;

    // Event vector, bit order matches the flag field
    typedef struct packed {
        logic jabber;
        logic rx_error;
        logic page_rx;
        logic pd_fault;
        logic partner_ack;
        logic link_down;
        logic remote_fault;
        logic link_up;
    } pev_events_t;

    // Management register access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pev_mgmt_req_t;

    // Received partner next page word
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } pev_page_t;
endpackage

// file: verilog/pev_regs.sv
/*
 Partner next page, receive symbol error counter and event enable/flag registers
 of the management register slice.
 Assumes the serial management framing outside turns each access into a one-cycle
 rd or wr strobe, and that event inputs are one-cycle pulses on clk.
 Assumes the link side presents a received partner page as one word with a
 one-cycle valid, and flags each symbol error frame with a one-cycle pulse.
 Reads answer one cycle after the strobe, with zero for unmapped addresses.
 Events and the counter are sampled on every edge, reads included, so a source
 pulse that meets a clearing read is kept for the next read.
 The counter stops at its top value instead of wrapping; only a read clears it.
 Partner page fields keep the last valid word until the next one arrives.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Enable bit 15 lets jabber events raise the interrupt; resets zero.
// - Enable bit 14 gates receive error events onto the interrupt; resets zero.
// - Enable bit 13 gates page received events; resets zero.
// - Enable bit 12 gates parallel detect fault events; resets zero.
// - Enable bit 11 gates partner acknowledge events; resets zero.
// - Enable bit 10 gates link down events; resets zero.
// - Enable bit 9 gates remote fault events; resets zero.
// - Enable bit 8 gates link up events; resets zero.
// - Flag bit 7 sets on jabber, clears on read, resets zero.
// - Flag bit 6 sets on receive error, clears on read.
// - Flag bit 5 sets on page received, clears on read.
// - Flag bit 4 sets on parallel detect fault, clears on read.
// - 16-bit symbol error frame counter, cleared on read, zero after reset.
// - Partner acknowledge bit shows successful receipt of link word.
// - Partner message page bit: one message page, zero unformatted.
// - Partner second acknowledge bit: partner able to act on information.
// - Partner toggle bit: one when previous transmitted word was zero.
// - Flags 3 to 0: partner ack, link down, remote fault, link up.
module pev_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Management access
    input pev_pkg::pev_mgmt_req_t mgmt_req,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    // Link side events and received page
    input pev_pkg::pev_events_t events,
    input wire logic symbol_err_frame,
    input pev_pkg::pev_page_t partner_page,
    // Interrupt
    output logic irq
);
    // Event enables and flags, bit 7 jabber down to bit 0 link up
    logic [7:0] event_en;
    logic [7:0] next_event_en;
    logic [7:0] event_flag;
    logic [7:0] next_event_flag;

    // Symbol error frame counter
    logic [15:0] err_cnt;
    logic [15:0] next_err_cnt;
    logic [15:0] cnt_plus;
    logic cnt_full;
    logic cnt_bump;
    logic frame_in_read;

    // Partner next page, one register per field
    logic page_more;
    logic next_page_more;

    logic page_ack;
    logic next_page_ack;

    logic page_msg;
    logic next_page_msg;

    logic page_ack2;
    logic next_page_ack2;

    logic page_toggle;
    logic next_page_toggle;

    logic [10:0] page_field;
    logic [10:0] next_page_field;

    // Read port
    logic [15:0] next_mgmt_rdata;
    logic next_mgmt_rvalid;

    // Interrupt
    logic next_irq;
    logic [7:0] pend;

    // Access decode
    logic hit_page;
    logic hit_cnt;
    logic hit_event;
    logic rd_page;
    logic rd_event;
    logic rd_cnt;
    logic wr_event;

    // Input views
    logic [7:0] evt_vec;
    logic [7:0] en_wdata;
    logic [15:0] page_in;

    // Register views for the read mux
    logic [15:0] page_view;
    logic [15:0] cnt_view;
    logic [15:0] event_view;

    // Address match, shared by reads and writes
    assign hit_page = (mgmt_req.addr == pev_pkg::ADDR_PARTNER_NEXT_PAGE);
    assign hit_cnt = (mgmt_req.addr == pev_pkg::ADDR_RX_SYMBOL_ERR_CNT);
    assign hit_event = (mgmt_req.addr == pev_pkg::ADDR_EVENT_CTRL);

    // Reads and writes decode apart; both may act in one cycle
    assign rd_page = mgmt_req.rd && hit_page;
    assign rd_event = mgmt_req.rd && hit_event;
    assign rd_cnt = mgmt_req.rd && hit_cnt;
    assign wr_event = mgmt_req.wr && hit_event;

    // Only the enable half of the event register is writable
    assign en_wdata = mgmt_req.wdata[pev_pkg::EN_LSB +: 8];
    assign page_in = partner_page.word;

    assign evt_vec[7] = events.jabber;

    assign evt_vec[6] = events.rx_error;

    assign evt_vec[5] = events.page_rx;

    assign evt_vec[4] = events.pd_fault;

    // Partner ack, link down, remote fault, link up
    assign evt_vec[3] = events.partner_ack;
    assign evt_vec[2] = events.link_down;
    assign evt_vec[1] = events.remote_fault;
    assign evt_vec[0] = events.link_up;

    // Enable bits and sticky flags, one slice per event
    for (genvar i = 0; i < 8; i++) begin : g_evt
        // Enable half
        always_comb begin
            next_event_en[i] = event_en[i];
            if (wr_event) begin
                next_event_en[i] = en_wdata[i];
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                event_en[i] <= pev_pkg::EVENT_EN_RST[i];
            end else begin
                event_en[i] <= next_event_en[i];
            end
        end

        // Flag half
        always_comb begin
            next_event_flag[i] = event_flag[i];
            if (rd_event) begin
                next_event_flag[i] = 1'b0;
            end

            // New event wins over the read clear so none is lost
            if (evt_vec[i]) begin
                next_event_flag[i] = 1'b1;
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                event_flag[i] <= pev_pkg::EVENT_FLAG_RST[i];
            end else begin
                event_flag[i] <= next_event_flag[i];
            end
        end

        // Flag counts only with its enable
        assign pend[i] = next_event_flag[i] & next_event_en[i];
    end

    // Full when every bit is set; the sum is only taken below that
    assign cnt_full = (err_cnt == pev_pkg::ERR_CNT_MAX);
    assign cnt_plus = err_cnt + 16'h0001;
    assign frame_in_read = rd_cnt && symbol_err_frame;
    assign cnt_bump = symbol_err_frame && !cnt_full && !rd_cnt;

    always_comb begin
        next_err_cnt = err_cnt;

        if (rd_cnt) begin
            next_err_cnt = pev_pkg::ERR_CNT_RST;
        end

        // A frame in the read cycle starts the new count at one
        if (frame_in_read) begin
            next_err_cnt = pev_pkg::ERR_CNT_RST + 16'h0001;
        end

        // Saturate rather than wrap, so a full count is never mistaken for few
        if (cnt_bump) begin
            next_err_cnt = cnt_plus;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            err_cnt <= pev_pkg::ERR_CNT_RST;
        end else begin
            err_cnt <= next_err_cnt;
        end
    end

    always_comb begin
        // Hold unless a page arrives
        next_page_more = page_more;
        next_page_ack = page_ack;
        next_page_msg = page_msg;
        next_page_ack2 = page_ack2;
        next_page_toggle = page_toggle;
        next_page_field = page_field;

        // Next page bit as received
        if (partner_page.valid) begin
            next_page_more = page_in[pev_pkg::PNP_NEXT];
        end

        if (partner_page.valid) begin
            next_page_ack = page_in[pev_pkg::PNP_ACK];
        end

        if (partner_page.valid) begin
            next_page_msg = page_in[pev_pkg::PNP_MSG];
        end

        if (partner_page.valid) begin
            next_page_ack2 = page_in[pev_pkg::PNP_ACK2];
        end

        if (partner_page.valid) begin
            next_page_toggle = page_in[pev_pkg::PNP_TOGGLE];
        end

        // Message field sits below the toggle bit
        if (partner_page.valid) begin
            next_page_field = page_in[pev_pkg::PNP_TOGGLE - 1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            page_more <= pev_pkg::PARTNER_PAGE_RST[pev_pkg::PNP_NEXT];
            page_ack <= pev_pkg::PARTNER_PAGE_RST[pev_pkg::PNP_ACK];
            page_msg <= pev_pkg::PARTNER_PAGE_RST[pev_pkg::PNP_MSG];
            page_ack2 <= pev_pkg::PARTNER_PAGE_RST[pev_pkg::PNP_ACK2];
            page_toggle <= pev_pkg::PARTNER_PAGE_RST[pev_pkg::PNP_TOGGLE];
            page_field <= pev_pkg::PARTNER_PAGE_RST[pev_pkg::PNP_TOGGLE - 1:0];
        end else begin
            page_more <= next_page_more;
            page_ack <= next_page_ack;
            page_msg <= next_page_msg;
            page_ack2 <= next_page_ack2;
            page_toggle <= next_page_toggle;
            page_field <= next_page_field;
        end
    end

    // Fields put back in their places for reads
    always_comb begin
        page_view = pev_pkg::PARTNER_PAGE_RST;
        page_view[pev_pkg::PNP_NEXT] = page_more;
        page_view[pev_pkg::PNP_ACK] = page_ack;
        page_view[pev_pkg::PNP_MSG] = page_msg;
        page_view[pev_pkg::PNP_ACK2] = page_ack2;
        page_view[pev_pkg::PNP_TOGGLE] = page_toggle;
        page_view[pev_pkg::PNP_TOGGLE - 1:0] = page_field;
    end

    assign cnt_view = err_cnt;

    // Enable half above flag half
    always_comb begin
        event_view = 16'h0000;
        event_view[pev_pkg::EN_LSB +: 8] = event_en;
        event_view[pev_pkg::FLAG_LSB +: 8] = event_flag;
    end

    always_comb begin
        next_mgmt_rvalid = mgmt_req.rd;
        // Unmapped reads answer zero but still answer
        next_mgmt_rdata = 16'h0000;

        // Partner page
        if (rd_page) begin
            next_mgmt_rdata = page_view;
        end

        // Counter
        if (rd_cnt) begin
            next_mgmt_rdata = cnt_view;
        end

        // Event register
        if (rd_event) begin
            next_mgmt_rdata = event_view;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mgmt_rdata <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rdata <= next_mgmt_rdata;
            mgmt_rvalid <= next_mgmt_rvalid;
        end
    end

    // Summary from next state, so irq needs no extra cycle
    always_comb begin
        next_irq = |pend;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end
endmodule

// file: bench/pev_props.sv
/* Checker on the pev_regs ports.
 Assumes it is bound from the testbench top. */
`timescale 1ns/1ps
module pev_props (
    // Clock, reset
    input wire logic clk,
    input wire logic rst,
    // Ports watched
    input pev_pkg::pev_mgmt_req_t mgmt_req,
    input logic [15:0] mgmt_rdata,
    input logic mgmt_rvalid,
    input pev_pkg::pev_events_t events,
    input wire logic symbol_err_frame,
    input pev_pkg::pev_page_t partner_page,
    input logic irq
);
    wire rb = mgmt_req.rd && mgmt_req.addr == 5'h1B && events == '0;
    wire rc = mgmt_req.rd && mgmt_req.addr == 5'h15 && !symbol_err_frame;
    wire ok = mgmt_req.addr inside {5'h08, 5'h15, 5'h1B};
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    a_unmapped_reads_zero: assert property (mgmt_req.rd && !ok |=> mgmt_rdata == 16'h0000)
        else $error("unmapped read");
    a_jabber_flag_set: assert property (events.jabber ##1 !mgmt_req.rd [*3] ##1 rb
        |=> mgmt_rdata[7]) else $error("jabber flag");
    a_link_up_flag: assert property (events.link_up ##1 !mgmt_req.rd [*3] ##1 rb
        |=> mgmt_rdata[0]) else $error("link up flag");
    a_flags_clear_read: assert property (rb ##1 events == '0 ##1 rb
        |=> mgmt_rdata[7:0] == 8'h00) else $error("flags kept");
    a_count_clear_read: assert property (rc ##1 !symbol_err_frame ##1 rc
        |=> mgmt_rdata == 16'h0000) else $error("count kept");
    a_page_word_held: assert property (partner_page.valid ##1 !partner_page.valid [*2]
        ##0 mgmt_req.addr == 5'h08 && mgmt_req.rd
        |=> mgmt_rdata == $past(partner_page.word, 3)) else $error("page word");
    a_irq_drops_read: assert property (rb && !mgmt_req.wr |=> !irq) else $error("irq");
    a_enable_read_back: assert property (mgmt_req.wr && mgmt_req.addr == 5'h1B
        ##1 !mgmt_req.wr ##1 rb |=> mgmt_rdata[15:8] == $past(mgmt_req.wdata[15:8], 3))
        else $error("enable bits");
endmodule

// file: bench/pev_mgr.sv
/* Management controller model issuing single register accesses.
 Assumes the block answers a read one edge after the strobe. */
`timescale 1ns/1ps
module pev_mgr (
    // Clock
    input wire logic clk,
    // Block answer and request
    input logic [15:0] mgmt_rdata,
    input logic mgmt_rvalid,
    output pev_pkg::pev_mgmt_req_t mgmt_req
);
    initial mgmt_req = '0;
    // Idle bus shows inverted values, so a stale address never looks valid
    task automatic acc(input logic r, input logic [4:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(negedge clk);
        mgmt_req = '{r, !r, a, d};
        @(negedge clk);
        mgmt_req = '{1'b0, 1'b0, ~a, ~d};
        q = mgmt_rvalid ? mgmt_rdata : 16'hDEAD;
    endtask
endmodule

// file: bench/testbench.sv
/* Top bench for pev_regs: register accesses, events, page, counter.
 Assumes the controller model and checker sit beside it. */
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pev_pkg::pev_mgmt_req_t mgmt_req;
    logic [15:0] mgmt_rdata, q;
    logic mgmt_rvalid, irq;
    pev_pkg::pev_events_t events = '0;
    logic symbol_err_frame = 1'b0;
    pev_pkg::pev_page_t partner_page = '0;
    int n_errors = 0;
    int checks = 0;
    always #4 clk = ~clk;
    pev_regs dut_u (.clk(clk), .rst(rst), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .events(events), .symbol_err_frame(symbol_err_frame),
        .partner_page(partner_page), .irq(irq));
    pev_mgr mgr_u (.clk(clk), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
        .mgmt_req(mgmt_req));
    task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", w, e, s);
        end
    endtask
    task automatic rd(input string w, input logic [4:0] a, input logic [15:0] e);
        mgr_u.acc(1'b1, a, 16'h0000, q);
        chk(w, q, e);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgr_u.acc(1'b0, a, d, q);
    endtask
    task automatic close_out;
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        rd("ev_rst", 5'h1B, 16'h0000);
        rd("unmapped", 5'h00, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr(5'h1B, 16'hFF00 ^ (16'h0100 << i));
            @(negedge clk);
            events = 8'h01 << i;
            @(negedge clk);
            events = '0;
            chk("irq_masked", {15'h0000, irq}, 16'h0000);
            wr(5'h1B, 16'hFF00);
            chk("irq_on", {15'h0000, irq}, 16'h0001);
            rd("flag", 5'h1B, 16'hFF00 | (16'h0001 << i));
            rd("flag_clr", 5'h1B, 16'hFF00);
            chk("irq_off", {15'h0000, irq}, 16'h0000);
        end
        repeat (3) begin
            @(negedge clk);
            symbol_err_frame = 1'b1;
            @(negedge clk);
            symbol_err_frame = 1'b0;
        end
        wr(5'h15, 16'h1234);
        rd("cnt", 5'h15, 16'h0003);
        rd("cnt_clr", 5'h15, 16'h0000);
        for (int i = 11; i < 15; i++) begin
            @(negedge clk);
            partner_page = {1'b1, 16'h0001 << i};
            @(negedge clk);
            partner_page = '0;
            rd("page", 5'h08, 16'h0001 << i);
        end
        close_out();
    end
    // Whole run is about 120 cycles
    initial begin
        #20000;
        n_errors++;
        close_out();
    end
endmodule
bind pev_regs pev_props props_u (.clk(clk), .rst(rst), .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .events(events),
    .symbol_err_frame(symbol_err_frame), .partner_page(partner_page), .irq(irq));
